// ---- rtcc_core.sv ----
// rtcc_core: prescaled 32-bit counter / 16-bit counter / calendar with register port
//
// Functional notes
// - only power-on reset or the soft reset bit returns the block to its initial state.
// - debug halt stops counting unless debug_control requests running on.
// - write protection covers all writable registers except flags, read request, status, debug control.
// - ten-bit prescaler divides source clock by two to the setting, feeding the counter.
// - mode 0 wide counter, mode 1 narrow counter with period, mode 2 calendar.
// - mode, prescaler, clear-on-match, hour format, event control ignored while enabled.
// - enable-protected writes during disabling are held and applied afterwards.
// - enable bit one starts the block, zero stops it.
// - soft reset clears every register except debug control and disables the block.
// - wide mode counts each tick, wraps all-ones to zero, raises overflow.
// - wide mode match with compare 0 raises compare flag 0 on next tick.
// - wide clear-on-match clears counter next tick, raising compare 0 and overflow.
// - narrow mode counts to period, wraps to zero, raises overflow.
// - narrow mode matches with two compares raise their own flags next tick.
// - calendar holds seconds to year; hour format picks 12 or 24 hours.
// - day and month count from one; year is an offset.
// - February has a leap day when year offset divides by four.
// - after year 63 last second wraps to year 0 start, raising overflow.
// - calendar matches alarm value and raises alarm flag on next tick.
// - alarm mask select chooses which fields take part in the match.
// - calendar clear-on-match clears clock next tick, raising alarm and overflow.
// - synchronized writes set sync pending at once until the transfer completes.
// - interrupt asserted while any enabled flag is set.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module rtcc_core
	import rtcc_pkg::*;
#(
	parameter int PRESC_W = 10,
	parameter int CNT_W   = 32
) (
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	input  wire logic              source_clock_i,
	input  wire logic              dbg_halt_i,
	input  wire logic              wprot_i,
	input  wire logic              dbg_access_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   irq_o,
	output logic      [FLAG_W-1:0] event_o,
	output logic                   count_tick_o
);

	if (PRESC_W != 10 || CNT_W != 32) begin : g_bad_param
		$error("rtcc_core: only a 10-bit prescaler and 32-bit counter are served");
	end

	// ==========================================================
	// helper functions
	function automatic logic [4:0] days_in_month(input logic [3:0] mon, input logic [5:0] yr);
		unique case (mon)
			4'h2:                      days_in_month = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb:    days_in_month = 5'h1e;
			default:                   days_in_month = 5'h1f;
		endcase
	endfunction : days_in_month

	function automatic logic [32:0] cal_next(input logic [31:0] c, input logic h12);
		logic [31:0] n;
		logic        rolled;
		logic        of;
		n      = c;
		rolled = 1'b0;
		of     = 1'b0;
		if (c[SEC_LO+:6] != LAST_SEC) begin
			n[SEC_LO+:6] = 6'(c[SEC_LO+:6] + 6'h1);
		end else begin
			n[SEC_LO+:6] = 6'h0;
			if (c[MIN_LO+:6] != LAST_SEC) begin
				n[MIN_LO+:6] = 6'(c[MIN_LO+:6] + 6'h1);
			end else begin
				n[MIN_LO+:6] = 6'h0;
				if (!h12) begin
					if (c[HOUR_LO+:5] != LAST_HOUR24) n[HOUR_LO+:5] = 5'(c[HOUR_LO+:5] + 5'h1);
					else begin
						n[HOUR_LO+:5] = 5'h0;
						rolled        = 1'b1;
					end
				end else if (c[HOUR_LO+:4] == HOUR12_LAST) begin
					n[HOUR_LO+:5] = {~c[HOUR_LO+4], HOUR12_TOP};
					rolled        = c[HOUR_LO+4];
				end else if (c[HOUR_LO+:4] == HOUR12_TOP) begin
					n[HOUR_LO+:4] = 4'h1;
				end else begin
					n[HOUR_LO+:4] = 4'(c[HOUR_LO+:4] + 4'h1);
				end
				if (rolled) begin
					if (c[DAY_LO+:5] < days_in_month(c[MON_LO+:4], c[YEAR_LO+:6])) begin
						n[DAY_LO+:5] = 5'(c[DAY_LO+:5] + 5'h1);
					end else begin
						n[DAY_LO+:5] = 5'h1;
						if (c[MON_LO+:4] != LAST_MONTH) n[MON_LO+:4] = 4'(c[MON_LO+:4] + 4'h1);
						else begin
							n[MON_LO+:4] = 4'h1;
							if (c[YEAR_LO+:6] != LAST_YEAR) n[YEAR_LO+:6] = 6'(c[YEAR_LO+:6] + 6'h1);
							else begin
								n[YEAR_LO+:6] = 6'h0;
								of            = 1'b1;
							end
						end
					end
				end
			end
		end
		cal_next = {of, n};
	endfunction : cal_next

	function automatic logic alarm_hit(input logic [31:0] c, input logic [31:0] a, input logic [MASK_W-1:0] sel);
		logic [31:0] m;
		unique case (sel)
			3'h1:    m = 32'h0000003f;
			3'h2:    m = 32'h00000fff;
			3'h3:    m = 32'h0001ffff;
			3'h4:    m = 32'h003fffff;
			3'h5:    m = 32'h03ffffff;
			3'h6:    m = 32'hffffffff;
			default: m = 32'h0;
		endcase
		alarm_hit = (m != 32'h0) && (((c ^ a) & m) == 32'h0);
	endfunction : alarm_hit

	// ==========================================================
	// storage
	logic [PRESC_W-1:0]  presc_ff;
	logic                src_d_ff;
	logic                ctrl_en_ff;
	logic                active_ff;
	logic [1:0]          mode_ff;
	logic [PSC_SEL_W-1:0] psc_ff;
	logic                com_ff;
	logic                hfmt_ff;
	logic [FLAG_W-1:0]   event_control_ff;
	logic [FLAG_W-1:0]   inten_ff;
	logic [FLAG_W-1:0]   flag_ff;
	logic                dbg_run_ff;
	logic [CNT_W-1:0]    cnt_ff;
	logic [15:0]         per_ff;
	logic [31:0]         compare_value_0_ff;
	logic [15:0]         comp1_ff;
	logic [MASK_W-1:0]   mask_ff;
	logic [RREQ_W-1:0]   rreq_ff;
	logic                swrst_pend_ff;
	logic                hold_ctrl_v_ff;
	logic [15:0]         hold_ctrl_ff;
	logic                hold_ev_v_ff;
	logic [FLAG_W-1:0]   hold_ev_ff;
	rtcc_sync_t          sync_st_ff;
	logic [2:0]          sync_cnt_ff;

	// ==========================================================
	// bus decode
	wire logic prot_on    = wprot_i && !dbg_access_i;
	wire logic wr_ok      = wr_i && !prot_on;
	wire logic wr_ctrl    = wr_ok && (addr_i == OFS_CTRL);
	wire logic wr_ev      = wr_ok && (addr_i == OFS_EVENT_CONTROL);
	wire logic wr_inten   = wr_ok && (addr_i == OFS_INTEN);
	wire logic wr_flag    = wr_i && (addr_i == OFS_INTERRUPT_FLAGS);
	wire logic wr_dbg     = wr_i && (addr_i == OFS_DEBUG_CONTROL);
	wire logic wr_rreq    = wr_i && (addr_i == OFS_READ_REQUEST);
	wire logic wr_cnt     = wr_ok && (addr_i == OFS_COUNT);
	wire logic wr_per     = wr_ok && (addr_i == OFS_PER);
	wire logic wr_compare_value_0   = wr_ok && (addr_i == OFS_COMPARE_VALUE_0);
	wire logic wr_comp1   = wr_ok && (addr_i == OFS_COMP1);
	wire logic wr_mask    = wr_ok && (addr_i == OFS_MASK0);
	wire logic wr_synced  = wr_ctrl || wr_cnt || wr_per || wr_compare_value_0 || wr_comp1 || wr_mask;
	wire logic disabling  = !ctrl_en_ff && active_ff;
	wire logic locked     = ctrl_en_ff || (wr_ctrl && wdata_i[CTRL_EN]);
	wire logic sync_done  = (sync_st_ff == RTCC_SYNC_BUSY) && (sync_cnt_ff == 3'h1);
	wire logic swrst_go   = sync_done && swrst_pend_ff;
	wire logic cfg_apply  = wr_ctrl && !locked && !disabling;
	wire logic cfg_hold   = wr_ctrl && !locked && disabling;
	wire logic ev_apply   = wr_ev && !ctrl_en_ff && !disabling;
	wire logic ev_hold    = wr_ev && !ctrl_en_ff && disabling;
	wire logic held_go    = !disabling && !ctrl_en_ff;

	// ==========================================================
	// prescaler and count tick
	wire logic           src_rise  = source_clock_i && !src_d_ff;
	wire logic           running   = active_ff && (!dbg_halt_i || dbg_run_ff);
	wire logic [PRESC_W-1:0] psc_mask = (psc_ff == 4'h0) ? '0 : PRESC_W'((1 << psc_ff) - 1);
	wire logic           psc_valid = (psc_ff <= 4'(PRESC_W));
	wire logic           tick      = running && src_rise && psc_valid && ((presc_ff & psc_mask) == psc_mask);

	// ==========================================================
	// counting and matching
	wire logic [32:0] cal_inc   = cal_next(cnt_ff, hfmt_ff);
	wire logic        m_wide    = (cnt_ff == compare_value_0_ff);
	wire logic        m_n0      = (cnt_ff[15:0] == compare_value_0_ff[15:0]);
	wire logic        m_n1      = (cnt_ff[15:0] == comp1_ff);
	wire logic        m_alarm   = alarm_hit(cnt_ff, compare_value_0_ff, mask_ff);
	logic [CNT_W-1:0]  cnt_step;
	logic [FLAG_W-1:0] flag_set;

	always_comb begin
		cnt_step = cnt_ff;
		flag_set = '0;
		if (tick) begin
			unique case (mode_ff)
				MODE_WIDE: begin
					cnt_step = CNT_W'(cnt_ff + 32'h1);
					flag_set[FLG_OVF]  = (cnt_ff == 32'hffffffff);
					flag_set[FLG_COMPARE_FLAG_0] = m_wide;
					if (com_ff && m_wide) begin
						cnt_step          = WORD_RST;
						flag_set[FLG_OVF] = 1'b1;
					end
				end
				MODE_NARROW: begin
					cnt_step           = {16'h0, 16'(cnt_ff[15:0] + 16'h1)};
					if (cnt_ff[15:0] == per_ff) begin
						cnt_step          = WORD_RST;
						flag_set[FLG_OVF] = 1'b1;
					end
					flag_set[FLG_COMPARE_FLAG_0] = m_n0;
					flag_set[FLG_CMP1] = m_n1;
				end
				MODE_CAL: begin
					cnt_step           = cal_inc[31:0];
					flag_set[FLG_OVF]  = cal_inc[32];
					flag_set[FLG_COMPARE_FLAG_0] = m_alarm;
					if (com_ff && m_alarm) begin
						cnt_step          = WORD_RST;
						flag_set[FLG_OVF] = 1'b1;
					end
				end
				default: cnt_step = cnt_ff;
			endcase
		end
	end

	// flags: set wins over write-one-to-clear
	wire logic [FLAG_W-1:0] flag_clr = wr_flag ? wdata_i[FLAG_W-1:0] : '0;
	wire logic [FLAG_W-1:0] nxt_flag = (flag_ff & ~flag_clr) | flag_set;

	// ==========================================================
	// read mux
	logic [DATA_W-1:0] rd_word;
	always_comb begin
		unique case (addr_i)
			OFS_CTRL:    rd_word = {16'h0, 4'h0, psc_ff, com_ff, hfmt_ff, 2'h0, mode_ff, ctrl_en_ff, 1'b0};
			OFS_EVENT_CONTROL:  rd_word = {29'h0, event_control_ff};
			OFS_INTEN:   rd_word = {29'h0, inten_ff};
			OFS_INTERRUPT_FLAGS: rd_word = {29'h0, flag_ff};
			OFS_STATUS:  rd_word = {30'h0, active_ff, sync_st_ff == RTCC_SYNC_BUSY};
			OFS_DEBUG_CONTROL: rd_word = {31'h0, dbg_run_ff};
			OFS_COUNT:   rd_word = cnt_ff;
			OFS_PER:     rd_word = {16'h0, per_ff};
			OFS_COMPARE_VALUE_0:   rd_word = compare_value_0_ff;
			OFS_COMP1:   rd_word = {16'h0, comp1_ff};
			OFS_MASK0:   rd_word = {29'h0, mask_ff};
			OFS_READ_REQUEST: rd_word = {16'h0, rreq_ff};
			default:     rd_word = WORD_RST;
		endcase
	end

	// ==========================================================
	// registers: debug control, source sampler and read data by power-on reset only, the rest by power-on and soft reset
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dbg_run_ff <= 1'b0;
			src_d_ff   <= 1'b0;
			rdata_o    <= WORD_RST;
		end else begin
			if (wr_dbg) begin
				dbg_run_ff <= wdata_i[0];
			end
			src_d_ff <= source_clock_i;
			rdata_o  <= rd_i ? rd_word : WORD_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i || swrst_go) begin
			presc_ff   <= '0;
			ctrl_en_ff <= 1'b0;
			active_ff  <= 1'b0;
			mode_ff    <= MODE_WIDE;
			psc_ff     <= '0;
			com_ff     <= 1'b0;
			hfmt_ff    <= 1'b0;
			event_control_ff  <= '0;
			inten_ff   <= '0;
			flag_ff    <= '0;
			cnt_ff     <= WORD_RST;
			per_ff     <= 16'h0;
			compare_value_0_ff   <= WORD_RST;
			comp1_ff   <= 16'h0;
			mask_ff    <= '0;
			rreq_ff    <= '0;
			irq_o      <= 1'b0;
			event_o    <= '0;
			count_tick_o <= 1'b0;
			hold_ctrl_v_ff <= 1'b0;
			hold_ctrl_ff   <= 16'h0;
			hold_ev_v_ff   <= 1'b0;
			hold_ev_ff     <= '0;
		end else begin
			presc_ff <= running ? (src_rise ? PRESC_W'(presc_ff + 10'h1) : presc_ff) : '0;
			if (wr_ctrl) begin
				ctrl_en_ff <= wdata_i[CTRL_EN];
			end
			if (sync_done) begin
				active_ff <= ctrl_en_ff;
			end
			if (cfg_apply) begin
				mode_ff <= wdata_i[CTRL_MODE_LO+:2];
				psc_ff  <= wdata_i[CTRL_PSC_LO+:PSC_SEL_W];
				com_ff  <= wdata_i[CTRL_COM];
				hfmt_ff <= wdata_i[CTRL_HFMT];
			end else if (hold_ctrl_v_ff && held_go) begin
				mode_ff        <= hold_ctrl_ff[CTRL_MODE_LO+:2];
				psc_ff         <= hold_ctrl_ff[CTRL_PSC_LO+:PSC_SEL_W];
				com_ff         <= hold_ctrl_ff[CTRL_COM];
				hfmt_ff        <= hold_ctrl_ff[CTRL_HFMT];
			end
			if (cfg_hold) begin
				hold_ctrl_v_ff <= 1'b1;
				hold_ctrl_ff   <= wdata_i[15:0];
			end else if (held_go) begin
				hold_ctrl_v_ff <= 1'b0;
			end
			if (ev_apply) begin
				event_control_ff <= wdata_i[FLAG_W-1:0];
			end else if (hold_ev_v_ff && held_go) begin
				event_control_ff <= hold_ev_ff;
			end
			if (ev_hold) begin
				hold_ev_v_ff <= 1'b1;
				hold_ev_ff   <= wdata_i[FLAG_W-1:0];
			end else if (held_go) begin
				hold_ev_v_ff <= 1'b0;
			end
			if (wr_inten) begin
				inten_ff <= wdata_i[FLAG_W-1:0];
			end
			flag_ff      <= nxt_flag;
			cnt_ff       <= wr_cnt ? wdata_i : cnt_step;
			if (wr_per) begin
				per_ff <= wdata_i[15:0];
			end
			if (wr_compare_value_0) begin
				compare_value_0_ff <= wdata_i;
			end
			if (wr_comp1) begin
				comp1_ff <= wdata_i[15:0];
			end
			if (wr_mask) begin
				mask_ff <= wdata_i[MASK_W-1:0];
			end
			if (wr_rreq) begin
				rreq_ff <= wdata_i[RREQ_W-1:0];
			end
			irq_o        <= |(nxt_flag & inten_ff);
			event_o      <= flag_set & event_control_ff;
			count_tick_o <= tick;
		end
	end

	// ==========================================================
	// write synchronisation tracker
	always_ff @(posedge clk_i) begin
		if (!rstn_i || swrst_go) begin
			sync_st_ff    <= RTCC_SYNC_IDLE;
			sync_cnt_ff   <= 3'h0;
			swrst_pend_ff <= 1'b0;
		end else begin
			if (wr_synced) begin
				sync_st_ff  <= RTCC_SYNC_BUSY;
				sync_cnt_ff <= SYNC_CYC;
			end else if (sync_done) begin
				sync_st_ff  <= RTCC_SYNC_IDLE;
				sync_cnt_ff <= 3'h0;
			end else if (sync_st_ff == RTCC_SYNC_BUSY) begin
				sync_cnt_ff <= 3'(sync_cnt_ff - 3'h1);
			end
			if (wr_ctrl && wdata_i[SOFT_RESET_BIT]) begin
				swrst_pend_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	AST_SWRST_CLEARS: assert property (swrst_go |=> !active_ff && !ctrl_en_ff && cnt_ff == 32'h0 && flag_ff == 3'h0)
		else $error("soft reset left state behind");
	AST_DBG_HOLDS: assert property (dbg_halt_i && !dbg_run_ff && !wr_cnt |=> $stable(cnt_ff))
		else $error("counter moved during debug halt");
	AST_ENPROT: assert property (wr_ctrl && ctrl_en_ff && !hold_ctrl_v_ff |=> $stable(mode_ff) && $stable(psc_ff))
		else $error("protected field changed while enabled");
	AST_WIDE_WRAP: assert property (tick && mode_ff == MODE_WIDE && cnt_ff == 32'hffffffff && !wr_cnt
		|=> cnt_ff == 32'h0 && flag_ff[FLG_OVF])
		else $error("wide counter did not wrap with overflow");
	AST_NARROW_PER: assert property (tick && mode_ff == MODE_NARROW && cnt_ff[15:0] == per_ff && !wr_cnt
		|=> cnt_ff == 32'h0 && flag_ff[FLG_OVF])
		else $error("narrow counter did not wrap at period");
	AST_SYNC_BUSY: assert property (wr_synced |=> sync_st_ff == RTCC_SYNC_BUSY
		##2 (sync_st_ff == RTCC_SYNC_IDLE || $past(wr_synced) || $past(wr_synced, 2)))
		else $error("sync pending not raised and released");
	AST_IRQ: assert property (irq_o == |($past(flag_set | (flag_ff & ~flag_clr)) & $past(inten_ff)))
		else $error("interrupt line disagrees with flags");
	AST_W1C: assert property (wr_flag && wdata_i[FLG_CMP1] && !flag_set[FLG_CMP1] |=> !flag_ff[FLG_CMP1])
		else $error("flag not cleared by write one");
	AST_PROT_PER: assert property (wr_i && prot_on && addr_i == OFS_PER |=> $stable(per_ff))
		else $error("protected register written");
	AST_MATCH_CLR: assert property (tick && mode_ff == MODE_WIDE && com_ff && m_wide && !wr_cnt
		|=> cnt_ff == 32'h0 && flag_ff[FLG_OVF] && flag_ff[FLG_COMPARE_FLAG_0])
		else $error("clear on match failed");

endmodule : rtcc_core

`default_nettype wire

// ---- rtcc_pkg.sv ----
// rtcc_pkg: constants and types shared by the real-time counter core
package rtcc_pkg;

	// ==========================================================
	// register bus
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_EVENT_CONTROL   = 8'h04;
	localparam logic [7:0]  OFS_INTEN    = 8'h08;
	localparam logic [7:0]  OFS_INTERRUPT_FLAGS  = 8'h0c;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	localparam logic [7:0]  OFS_DEBUG_CONTROL  = 8'h14;
	localparam logic [7:0]  OFS_COUNT    = 8'h18;
	localparam logic [7:0]  OFS_PER      = 8'h1c;
	localparam logic [7:0]  OFS_COMPARE_VALUE_0    = 8'h20;
	localparam logic [7:0]  OFS_COMP1    = 8'h24;
	localparam logic [7:0]  OFS_MASK0    = 8'h28;
	localparam logic [7:0]  OFS_READ_REQUEST  = 8'h2c;

	// ==========================================================
	// control register fields
	localparam int          SOFT_RESET_BIT   = 0;
	localparam int          CTRL_EN      = 1;
	localparam int          CTRL_MODE_LO = 2;
	localparam int          CTRL_HFMT    = 6;
	localparam int          CTRL_COM     = 7;
	localparam int          CTRL_PSC_LO  = 8;
	localparam int          PSC_SEL_W    = 4;
	localparam logic [1:0]  MODE_WIDE    = 2'h0;
	localparam logic [1:0]  MODE_NARROW  = 2'h1;
	localparam logic [1:0]  MODE_CAL     = 2'h2;

	// ==========================================================
	// flags, events, status
	localparam int          FLAG_W       = 3;
	localparam int          FLG_OVF      = 0;
	localparam int          FLG_COMPARE_FLAG_0     = 1;
	localparam int          FLG_CMP1     = 2;
	localparam int          STS_SYNC     = 0;
	localparam int          STS_ACTIVE   = 1;
	localparam int          MASK_W       = 3;
	localparam int          RREQ_W       = 16;

	// ==========================================================
	// calendar layout
	localparam int          SEC_LO       = 0;
	localparam int          MIN_LO       = 6;
	localparam int          HOUR_LO      = 12;
	localparam int          DAY_LO       = 17;
	localparam int          MON_LO       = 22;
	localparam int          YEAR_LO      = 26;
	localparam logic [5:0]  LAST_SEC     = 6'h3b;
	localparam logic [4:0]  LAST_HOUR24  = 5'h17;
	localparam logic [3:0]  HOUR12_TOP   = 4'hc;
	localparam logic [3:0]  HOUR12_LAST  = 4'hb;
	localparam logic [3:0]  LAST_MONTH   = 4'hc;
	localparam logic [5:0]  LAST_YEAR    = 6'h3f;

	// ==========================================================
	// reset values and timing
	localparam logic [31:0] WORD_RST     = 32'h0;
	localparam logic [2:0]  SYNC_CYC     = 3'h2;

	typedef enum logic [1:0] {
		RTCC_SYNC_IDLE = 2'b01,
		RTCC_SYNC_BUSY = 2'b10
	} rtcc_sync_t;

endpackage : rtcc_pkg

// ---- tb.sv ----
// tb: self-checking testbench for the real-time counter core
`timescale 1ns/1ps
`default_nettype none

module tb
	import rtcc_pkg::*;
;
	// ==========================================================
	// stimulus and observation
	logic              clk;
	logic              rstn;
	logic              src;
	logic              halt;
	logic              wprot;
	logic              dbg_acc;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr_s;
	logic              rd_s;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	logic [FLAG_W-1:0] evt;
	logic              ctick;
	int                num_errors;
	int                comparisons;
	logic [31:0]       c;
	int                ticks = 0;
	int                evs = 0;
	int                snap;

	// count tick and event pulses seen on the outputs
	always @(posedge clk) begin
		if (ctick === 1'b1) ticks <= ticks + 1;
		if ((|evt) === 1'b1) evs <= evs + 1;
	end

	rtcc_core u_rtcc_core (.clk_i(clk), .rstn_i(rstn), .source_clock_i(src), .dbg_halt_i(halt),
		.wprot_i(wprot), .dbg_access_i(dbg_acc), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
		.rd_i(rd_s), .rdata_o(rdata), .irq_o(irq), .event_o(evt), .count_tick_o(ctick));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// bus tasks and checks
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask : chk_rd

	// one source rise per loop, then let flags and irq settle
	task automatic tick(input int n);
		repeat (n) begin
			src <= 1'b1;
			idle(2);
			src <= 1'b0;
			idle(2);
		end
		idle(4);
	endtask : tick

	task automatic enable(input logic [31:0] cfg);
		wr(OFS_CTRL, cfg);
		wr(OFS_CTRL, cfg | 32'h2);
		idle(4);
	endtask : enable

	function automatic logic [31:0] cal(input int y, mo, d, h, mi, s);
		return {y[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
	endfunction : cal

	task automatic tally_and_finish();
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	// ==========================================================
	// scenarios
	initial begin
		{rstn, src, halt, wprot, dbg_acc, wr_s, rd_s} = 7'h0;
		addr = 8'h0;
		wdata = 32'h0;
		num_errors = 0;
		comparisons = 0;
		void'($urandom(32'ha427));
		idle(4);
		rstn <= 1'b1;
		chk_rd(OFS_CTRL, 32'hffffffff, 32'h0);
		chk_rd(OFS_INTERRUPT_FLAGS, 32'hffffffff, 32'h0);
		chk_rd(8'h30, 32'hffffffff, 32'h0);
		wr(OFS_COMPARE_VALUE_0, 32'h0);
		chk_rd(OFS_STATUS, 32'h1, 32'h1);
		idle(4);
		chk_rd(OFS_STATUS, 32'h1, 32'h0);
		// wide counter wrap, irq and flag clearing
		wr(OFS_COUNT, 32'hffffffff);
		wr(OFS_INTEN, 32'h1);
		enable(32'h0);
		chk_rd(OFS_STATUS, 32'h2, 32'h2);
		tick(1);
		chk_rd(OFS_COUNT, 32'hffffffff, 32'h0);
		chk_rd(OFS_INTERRUPT_FLAGS, 32'h7, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_INTERRUPT_FLAGS, 32'h0);
		chk_rd(OFS_INTERRUPT_FLAGS, 32'h1, 32'h1);
		wr(OFS_INTERRUPT_FLAGS, 32'h7);
		idle(3);
		chk({31'h0, irq}, 32'h0);
		// protected fields ignored while enabled
		wr(OFS_CTRL, 32'h0000030a);
		wr(OFS_EVENT_CONTROL, 32'h7);
		chk_rd(OFS_CTRL, 32'hffffffff, 32'h2);
		chk_rd(OFS_EVENT_CONTROL, 32'hffffffff, 32'h0);
		// random compare values
		repeat (4) begin
			c = $urandom();
			wr(OFS_COMPARE_VALUE_0, c);
			wr(OFS_COUNT, c - 32'h1);
			wr(OFS_INTERRUPT_FLAGS, 32'h7);
			idle(4);
			tick(2);
			chk_rd(OFS_INTERRUPT_FLAGS, 32'h2, 32'h2);
			chk_rd(OFS_COUNT, 32'hffffffff, c + 32'h1);
		end
		// debug halt, then run-in-debug
		snap = ticks;
		halt <= 1'b1;
		tick(2);
		chk_rd(OFS_COUNT, 32'hffffffff, c + 32'h1);
		chk(ticks - snap, 32'h0);
		wr(OFS_DEBUG_CONTROL, 32'h1);
		tick(1);
		chk_rd(OFS_COUNT, 32'hffffffff, c + 32'h2);
		chk(ticks - snap, 32'h1);
		halt <= 1'b0;
		wr(OFS_DEBUG_CONTROL, 32'h0);
		// clear on match in wide mode
		wr(OFS_CTRL, 32'h0);
		idle(4);
		enable(32'h80);
		wr(OFS_COMPARE_VALUE_0, 32'h5);
		wr(OFS_COUNT, 32'h5);
		wr(OFS_INTERRUPT_FLAGS, 32'h7);
		idle(4);
		tick(1);
		chk_rd(OFS_COUNT, 32'hffffffff, 32'h0);
		chk_rd(OFS_INTERRUPT_FLAGS, 32'h7, 32'h3);
		// write protection and debugger bypass
		wprot <= 1'b1;
		wr(OFS_COMPARE_VALUE_0, 32'h1234);
		wr(OFS_DEBUG_CONTROL, 32'h1);
		chk_rd(OFS_COMPARE_VALUE_0, 32'hffffffff, 32'h5);
		chk_rd(OFS_DEBUG_CONTROL, 32'h1, 32'h1);
		dbg_acc <= 1'b1;
		wr(OFS_COMPARE_VALUE_0, 32'h1234);
		chk_rd(OFS_COMPARE_VALUE_0, 32'hffffffff, 32'h1234);
		{wprot, dbg_acc} <= 2'b00;
		// narrow counter with period and two compares
		wr(OFS_CTRL, 32'h0);
		idle(4);
		wr(OFS_PER, 32'h3);
		wr(OFS_COMPARE_VALUE_0, 32'h1);
		wr(OFS_COMP1, 32'h2);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_INTERRUPT_FLAGS, 32'h7);
		wr(OFS_EVENT_CONTROL, 32'h7);
		enable(32'h4);
		snap = evs;
		tick(4);
		chk(evs - snap, 32'h3);
		chk_rd(OFS_COUNT, 32'hffff, 32'h0);
		chk_rd(OFS_INTERRUPT_FLAGS, 32'h7, 32'h7);
		// protected write while disabling is held, then calendar mode
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h8);
		idle(6);
		chk_rd(OFS_CTRL, 32'hffffffff, 32'h8);
		chk_rd(OFS_STATUS, 32'h2, 32'h0);
		enable(32'h8);
		wr(OFS_COUNT, cal(63, 12, 31, 23, 59, 59));
		wr(OFS_INTERRUPT_FLAGS, 32'h7);
		idle(4);
		tick(1);
		chk_rd(OFS_COUNT, 32'hffffffff, cal(0, 1, 1, 0, 0, 0));
		chk_rd(OFS_INTERRUPT_FLAGS, 32'h1, 32'h1);
		for (int y = 4; y < 6; y++) begin
			wr(OFS_COUNT, cal(y, 2, 28, 23, 59, 59));
			idle(4);
			tick(1);
			chk_rd(OFS_COUNT, 32'hffffffff, (y == 4) ? cal(y, 2, 29, 0, 0, 0) : cal(y, 3, 1, 0, 0, 0));
		end
		// alarm with seconds-only mask, then never-match mask
		wr(OFS_COMPARE_VALUE_0, cal(1, 1, 1, 0, 0, 30));
		for (int m = 1; m >= 0; m--) begin
			wr(OFS_MASK0, m);
			wr(OFS_COUNT, cal(9, 5, 5, 5, 5, 29));
			wr(OFS_INTERRUPT_FLAGS, 32'h7);
			idle(4);
			tick(2);
			chk_rd(OFS_INTERRUPT_FLAGS, 32'h2, m * 2);
		end
		// soft reset keeps debug control
		wr(OFS_CTRL, 32'h8);
		idle(4);
		wr(OFS_CTRL, 32'h1);
		idle(6);
		chk_rd(OFS_CTRL, 32'hffffffff, 32'h0);
		chk_rd(OFS_COMPARE_VALUE_0, 32'hffffffff, 32'h0);
		chk_rd(OFS_DEBUG_CONTROL, 32'h1, 32'h1);
		tally_and_finish();
	end
endmodule : tb

`default_nettype wire
